// file: fpw_ctrl.sv
// Frequency selection, watchdog supervision and recovery control.
module fpw_ctrl #(
	parameter logic [29:0] UNIT_SHORT_CYC = fpw_pkg::UNIT_SHORT_CYC,
	parameter logic [29:0] UNIT_LONG_CYC = fpw_pkg::UNIT_LONG_CYC
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST_N,
	// Strap pins, caught once after reset release.
	input wire logic [4:0] STRAP_RATIO_CODE,
	// Frequency control word.
	input wire logic FREQ_CTRL_WR,
	input wire fpw_pkg::fpw_freq_ctrl_t FREQ_CTRL_IN,
	// CPU N and M values.
	input wire logic CPU_NUM_WR,
	input wire logic [7:0] CPU_NUMERATOR_VALUE,
	input wire logic CPU_DEN_WR,
	input wire logic [6:0] CPU_DENOMINATOR_VALUE,
	// Recovery N and M values.
	input wire logic REC_NUM_WR,
	input wire logic [7:0] RECOVERY_NUMERATOR_VALUE,
	input wire logic REC_DEN_WR,
	input wire logic [6:0] RECOVERY_DENOMINATOR_VALUE,
	// Watchdog control word.
	input wire logic WD_CTRL_WR,
	input wire fpw_pkg::fpw_wd_ctrl_t WD_CTRL_IN,
	// Time-out flag write.
	input wire logic FLAG_WR,
	input wire logic FLAG_WDATA,
	// Frequency output to the PLL.
	output fpw_pkg::fpw_setting_t FREQ_SETTING,
	output logic FREQ_LOAD,
	// System reset and status.
	output logic SYS_RESET_PULSE,
	output logic WATCHDOG_TIMEOUT_FLAG,
	output logic RECOVERY_LOCKED,
	output logic WATCHDOG_RUNNING,
	output logic [4:0] STRAP_LATCHED,
	output fpw_pkg::fpw_freq_ctrl_t FREQ_CTRL_Q,
	output fpw_pkg::fpw_wd_ctrl_t WD_CTRL_Q
);

	typedef enum logic {
		ST_NORMAL,
		ST_RECOVERY
	} fpw_mode_t;

	fpw_mode_t mode_r;
	fpw_mode_t mode_nxt;

	// Stored configuration.
	fpw_pkg::fpw_freq_ctrl_t fctl_r;
	fpw_pkg::fpw_wd_ctrl_t wctl_r;
	logic [7:0] cpu_n_r;
	logic [6:0] cpu_m_r;
	logic [7:0] rec_n_r;
	logic [6:0] rec_m_r;
	logic [4:0] strap_r;
	logic strap_taken_r;

	// Output and event state.
	fpw_pkg::fpw_setting_t setting_r;
	fpw_pkg::fpw_setting_t setting_nxt;
	logic load_r;
	logic nm_wr_d_r;
	logic rec_wr_d_r;
	logic enter_r;
	logic flag_r;
	logic [7:0] rst_cnt_r;
	logic [7:0] rst_cnt_nxt;

	// Decode.
	logic locked;
	logic fctl_take;
	logic cpu_n_take;
	logic cpu_m_take;
	logic nm_take;
	logic wd_disable;
	logic [4:0] ratio_code;
	fpw_pkg::fpw_setting_t normal_setting;
	fpw_pkg::fpw_setting_t recov_setting;
	logic setting_change;
	logic load_nxt;
	logic freq_change;
	logic wd_start;
	logic wd_expire;
	logic wd_running;
	logic rst_trigger;
	logic flag_clear;
	logic rec_take;

	assign locked = (mode_r == ST_RECOVERY);

	// Frequency control and CPU N/M writes are refused while locked.
	assign fctl_take = FREQ_CTRL_WR && !locked;
	assign cpu_n_take = CPU_NUM_WR && !locked;
	assign cpu_m_take = CPU_DEN_WR && !locked;
	assign nm_take = cpu_n_take || cpu_m_take;
	assign wd_disable = WD_CTRL_WR && !WD_CTRL_IN.watchdog_enable;

	// Ratio and gear source follows the bypass bit, except in recovery with the strap setting.
	assign ratio_code = fctl_r.strap_bypass ? fctl_r.table_select_code
		: strap_r;

	// Programmable mode passes N+3 and M+3 on; the PLL forms the ratio.
	assign normal_setting = fpw_pkg::make_setting(fctl_r.prog_enable,
		ratio_code, cpu_n_r, cpu_m_r);

	// Recovery uses the strap setting or the recovery N/M pair.
	assign recov_setting = fpw_pkg::make_setting(
		wctl_r.recovery_source_choice, wctl_r.recovery_source_choice
		? ratio_code : strap_r, rec_n_r, rec_m_r);

	assign setting_nxt = locked ? recov_setting : normal_setting;
	assign setting_change = (setting_nxt != setting_r);

	// Recovery N/M writes count only while they drive the output.
	assign rec_take = (REC_NUM_WR || REC_DEN_WR) && locked
		&& wctl_r.recovery_source_choice;

	// A fresh N/M write or entry to recovery reloads even when the value
	// is unchanged, so the PLL always sees the request.
	assign load_nxt = strap_taken_r && (setting_change
		|| (nm_wr_d_r && fctl_r.prog_enable && !locked)
		|| (rec_wr_d_r && locked) || enter_r);

	// Events seen by the watchdog and the reset generator.
	assign freq_change = load_r && !locked;
	assign wd_start = freq_change && wctl_r.watchdog_enable;

	assign mode_nxt = wd_disable ? ST_NORMAL
		: (wd_expire ? ST_RECOVERY : mode_r);

	assign rst_trigger = (wd_expire && wctl_r.reset_on_timeout_enable)
		|| (freq_change && wctl_r.reset_on_freq_change_enable);
	assign rst_cnt_nxt = rst_trigger ? fpw_pkg::RST_PULSE_CYC
		: (rst_cnt_r != 8'h00 ? rst_cnt_r - 8'h01 : 8'h00);

	assign flag_clear = FLAG_WR && FLAG_WDATA;

	fpw_wdog #(
		.UNIT_SHORT(UNIT_SHORT_CYC),
		.UNIT_LONG(UNIT_LONG_CYC)
	) u_wdog (
		.clk(CLK),
		.rst_n(RST_N),
		.start(wd_start),
		.stop(wd_disable || !wctl_r.watchdog_enable),
		.unit_long(wctl_r.watchdog_time_unit),
		.timeout_value(wctl_r.watchdog_timeout_value),
		.expire(wd_expire),
		.running(wd_running)
	);

	// Strap pins are caught on the first edge after reset release.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			strap_r <= 5'h00;
			strap_taken_r <= 1'b0;
		end else if (!strap_taken_r) begin
			strap_r <= STRAP_RATIO_CODE;
			strap_taken_r <= 1'b1;
		end
	end

	// Frequency control word and CPU N/M.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			fctl_r <= fpw_pkg::FREQ_CTRL_RST;
			cpu_n_r <= fpw_pkg::NUM_RST;
			cpu_m_r <= fpw_pkg::DEN_RST;
			nm_wr_d_r <= 1'b0;
		end else begin
			if (fctl_take) begin
				fctl_r <= FREQ_CTRL_IN;
			end
			if (cpu_n_take) begin
				cpu_n_r <= CPU_NUMERATOR_VALUE;
			end
			if (cpu_m_take) begin
				cpu_m_r <= CPU_DENOMINATOR_VALUE;
			end
			nm_wr_d_r <= nm_take;
		end
	end

	// Recovery values and the watchdog control word.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rec_n_r <= fpw_pkg::NUM_RST;
			rec_m_r <= fpw_pkg::DEN_RST;
			wctl_r <= fpw_pkg::WD_CTRL_RST;
			rec_wr_d_r <= 1'b0;
		end else begin
			if (REC_NUM_WR) begin
				rec_n_r <= RECOVERY_NUMERATOR_VALUE;
			end
			if (REC_DEN_WR) begin
				rec_m_r <= RECOVERY_DENOMINATOR_VALUE;
			end
			if (WD_CTRL_WR) begin
				wctl_r <= WD_CTRL_IN;
			end
			rec_wr_d_r <= rec_take;
		end
	end

	// Mode, output setting, load strobe, reset pulse and flag.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_r <= ST_NORMAL;
			setting_r <= '0;
			load_r <= 1'b0;
			enter_r <= 1'b0;
			rst_cnt_r <= 8'h00;
			flag_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			setting_r <= setting_nxt;
			load_r <= load_nxt;
			enter_r <= wd_expire && !wd_disable;
			rst_cnt_r <= rst_cnt_nxt;
			if (wd_expire) begin
				flag_r <= 1'b1;
			end else if (flag_clear) begin
				flag_r <= 1'b0;
			end
		end
	end

	assign FREQ_SETTING = setting_r;
	assign FREQ_LOAD = load_r;
	assign SYS_RESET_PULSE = (rst_cnt_r != 8'h00);
	assign WATCHDOG_TIMEOUT_FLAG = flag_r;
	assign RECOVERY_LOCKED = locked;
	assign WATCHDOG_RUNNING = wd_running;
	assign STRAP_LATCHED = strap_r;
	assign FREQ_CTRL_Q = fctl_r;
	assign WD_CTRL_Q = wctl_r;

endmodule : fpw_ctrl

// file: fpw_ctrl_props.sv
// Concurrent checks on the ports of the frequency controller.
module fpw_ctrl_props (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST_N,
	// Write strobes and data.
	input wire logic FREQ_CTRL_WR,
	input wire logic CPU_NUM_WR,
	input wire logic REC_DEN_WR,
	input wire logic WD_CTRL_WR,
	input wire fpw_pkg::fpw_wd_ctrl_t WD_CTRL_IN,
	// Outputs.
	input wire fpw_pkg::fpw_setting_t FREQ_SETTING,
	input wire logic FREQ_LOAD,
	input wire logic SYS_RESET_PULSE,
	input wire logic WATCHDOG_TIMEOUT_FLAG,
	input wire logic RECOVERY_LOCKED,
	input wire logic WATCHDOG_RUNNING,
	input wire fpw_pkg::fpw_freq_ctrl_t FREQ_CTRL_Q,
	input wire fpw_pkg::fpw_wd_ctrl_t WD_CTRL_Q
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_cpu_load;
		CPU_NUM_WR && !RECOVERY_LOCKED && FREQ_CTRL_Q.prog_enable &&
		!FREQ_CTRL_WR |-> ##2 FREQ_LOAD && FREQ_SETTING.prog_mode;
	endproperty
	a_cpu_load: assert property (p_cpu_load) else $error("no load");
	property p_rec_load;
		REC_DEN_WR && RECOVERY_LOCKED && WD_CTRL_Q.recovery_source_choice &&
		!WD_CTRL_WR |-> ##2 FREQ_LOAD;
	endproperty
	a_rec_load: assert property (p_rec_load) else $error("no rec");
	property p_lock_ignore;
		RECOVERY_LOCKED && FREQ_CTRL_WR |=> $stable(FREQ_CTRL_Q);
	endproperty
	a_lock_ignore: assert property (p_lock_ignore) else $error("lock");
	property p_lock_entry;
		$rose(RECOVERY_LOCKED) |-> WATCHDOG_TIMEOUT_FLAG ##1 FREQ_LOAD;
	endproperty
	a_lock_entry: assert property (p_lock_entry) else $error("entry");
	property p_wd_reset;
		$rose(RECOVERY_LOCKED) && $past(WD_CTRL_Q.reset_on_timeout_enable)
		|-> SYS_RESET_PULSE;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("wd rst");
	property p_unlock;
		WD_CTRL_WR && !WD_CTRL_IN.watchdog_enable |=>
		!RECOVERY_LOCKED && !WATCHDOG_RUNNING;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock");
	property p_fc_reset;
		FREQ_LOAD && !RECOVERY_LOCKED &&
		WD_CTRL_Q.reset_on_freq_change_enable |=> SYS_RESET_PULSE;
	endproperty
	a_fc_reset: assert property (p_fc_reset) else $error("fc rst");
	property p_wd_start;
		FREQ_LOAD && !RECOVERY_LOCKED && WD_CTRL_Q.watchdog_enable &&
		!WD_CTRL_WR |=> WATCHDOG_RUNNING;
	endproperty
	a_wd_start: assert property (p_wd_start) else $error("start");
	property p_reset_prog;
		$rose(RST_N) |-> !FREQ_CTRL_Q.prog_enable && !FREQ_SETTING.prog_mode;
	endproperty
	a_reset_prog: assert property (p_reset_prog) else $error("prog");
	property p_pulse_len;
		$rose(SYS_RESET_PULSE) |-> SYS_RESET_PULSE [*8];
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("width");
	c_lock: cover property ($rose(RECOVERY_LOCKED));
	c_pulse: cover property ($rose(SYS_RESET_PULSE));
	c_prog: cover property (FREQ_LOAD && FREQ_SETTING.prog_mode);
endmodule : fpw_ctrl_props

bind fpw_ctrl fpw_ctrl_props fpw_ctrl_props_i (.*);

// file: fpw_ctrl_tb.sv
// Self-checking bench for the frequency and watchdog controller.
module fpw_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [6:0] stb = '0;
	logic [14:0] dat = '0;
	logic [4:0] strap = 5'h11;
	fpw_pkg::fpw_freq_ctrl_t fcq;
	fpw_pkg::fpw_wd_ctrl_t wdq;
	fpw_pkg::fpw_setting_t st;
	logic ld, rp, fl, lk, run;
	logic [4:0] sl;
	logic [15:0] pw, pc;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	always #2 clk = ~clk;
	fpw_ctrl #(.UNIT_SHORT_CYC(30'h00A), .UNIT_LONG_CYC(30'h028)) fpw_ctrl_i (
		.CLK(clk), .RST_N(rst_n), .STRAP_RATIO_CODE(strap),
		.FREQ_CTRL_WR(stb[0]), .FREQ_CTRL_IN(dat[6:0]),
		.CPU_NUM_WR(stb[1]), .CPU_NUMERATOR_VALUE(dat[14:7]),
		.CPU_DEN_WR(stb[2]), .CPU_DENOMINATOR_VALUE(dat[6:0]),
		.REC_NUM_WR(stb[3]), .RECOVERY_NUMERATOR_VALUE(dat[14:7]),
		.REC_DEN_WR(stb[4]), .RECOVERY_DENOMINATOR_VALUE(dat[6:0]),
		.WD_CTRL_WR(stb[5]), .WD_CTRL_IN(dat[9:0]),
		.FLAG_WR(stb[6]), .FLAG_WDATA(dat[0]),
		.FREQ_SETTING(st), .FREQ_LOAD(ld), .SYS_RESET_PULSE(rp),
		.WATCHDOG_TIMEOUT_FLAG(fl), .RECOVERY_LOCKED(lk),
		.WATCHDOG_RUNNING(run), .STRAP_LATCHED(sl),
		.FREQ_CTRL_Q(fcq), .WD_CTRL_Q(wdq));
	fpw_rst_sink fpw_rst_sink_i (.clk(clk), .rst_n(rst_n), .pulse(rp),
		.width_r(pw), .count_r(pc));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t seen %0h expected %0h", $time, s, e);
		end
	endtask : chk
	task automatic conclude();
		$display("mismatches %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	// One-cycle strobe on every bit of m with its data.
	task automatic wr(input logic [6:0] m, input logic [14:0] d);
		@(posedge clk);
		stb <= m;
		dat <= d;
		@(posedge clk);
		stb <= '0;
	endtask : wr
	// Waits for the load pulse, or for the flag when f is set.
	task automatic wt(input bit f, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((f ? fl : ld) !== 1'h1 && n < lim);
	endtask : wt
	task automatic wdog(input logic [9:0] w, input int lo, input int lim);
		wr(7'h20, {5'h00, w});
		wr(7'h02, {8'h4D, 7'h00});
		wt(0, 9);
		wt(1, lim);
		chk(n >= lo && n <= lo + 3, 1'h1);
		chk({lk, rp}, {1'h1, w[2]});
		wt(0, 3);
		chk(ld, 1'h1);
	endtask : wdog
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		wt(0, 5);
		chk({fcq.prog_enable, st.prog_mode}, 2'h0);
		chk({st.ratio_code, sl}, {5'h11, 5'h11});
		wr(7'h01, 15'h002F);
		wt(0, 9);
		chk({st.ratio_code, st.gear_sel}, {5'h0F, fpw_pkg::GEAR_G4});
		wr(7'h01, 15'h006F);
		wt(0, 9);
		chk({st.prog_mode, st.ratio_code, st.gear_sel},
			{1'h1, 5'h0F, fpw_pkg::GEAR_G4});
		wr(7'h01, 15'h004F);
		wt(0, 9);
		chk({st.ratio_code, st.gear_sel}, {5'h11, fpw_pkg::GEAR_G3});
		wr(7'h06, {8'h4D, 7'h30});
		wt(0, 9);
		chk({st.pll_mult, st.pll_div}, {9'h050, 8'h33});
		wr(7'h04, {8'h00, 7'h27});
		wt(0, 9);
		chk({ld, st.pll_div}, {1'h1, 8'h2A});
		wr(7'h20, 15'h0002);
		wr(7'h02, {8'h4E, 7'h00});
		repeat (270) @(posedge clk);
		chk({pc, pw}, {16'h0001, 8'h00, fpw_pkg::RST_PULSE_CYC});
		wr(7'h20, 15'h0000);
		wr(7'h02, {8'h4D, 7'h00});
		repeat (270) @(posedge clk);
		chk(pc, 16'h0001);
		wr(7'h18, {8'h6A, 7'h27});
		wdog(10'h21D, 40, 60);
		chk({st.pll_mult, st.pll_div, st.ratio_code},
			{9'h06D, 8'h2A, 5'h11});
		wr(7'h06, {8'h50, 7'h10});
		wt(0, 9);
		chk(ld, 1'h0);
		wr(7'h01, 15'h002F);
		#1;
		chk(fcq, 7'h4F);
		wr(7'h18, {8'h4D, 7'h30});
		wt(0, 9);
		chk(st.pll_mult, 9'h050);
		wr(7'h40, 15'h0000);
		@(posedge clk);
		#1;
		chk(fl, 1'h1);
		wr(7'h40, 15'h0001);
		@(posedge clk);
		#1;
		chk(fl, 1'h0);
		wr(7'h20, 15'h0000);
		@(posedge clk);
		#1;
		chk({lk, run}, 2'h0);
		chk({st.pll_mult, st.pll_div}, {9'h050, 8'h2A});
		wdog(10'h3F8, 1280, 1340);
		chk({st.prog_mode, st.ratio_code}, {1'h0, 5'h11});
		repeat (270) @(posedge clk);
		chk(pc, 16'h0002);
		conclude();
	end
endmodule : fpw_ctrl_tb

// file: fpw_pkg.sv
// Shared types, constants and decode helpers for the frequency controller.
// Notes on behaviour
// - Table mode: strap code or software code by bypass.
// - Programmable mode: gear times (N+3) over (M+3).
// - Programmable mode: bypass picks gear and ratio source.
// - A CPU N or M write starts a load in programmable mode when not locked.
// - A recovery N or M write starts a load only when locked with recovery N/M.
// - Time-out switches to strap or recovery N/M.
// - Recovery N/M ratio follows bypass: strap or software code; strap setting uses strap code.
// - Watchdog enable written 0 stops, reloads, unlocks.
// - Enabled watchdog starts counting after a frequency change.
// - Time-out: reset, recovery frequency, locked recovery mode.
// - Locked: frequency control and CPU N/M writes are ignored.
// - Time-out flag reads 1 after time-out; write 1 clears.
// - Five-bit time-out value scaled by the time unit.
// - Countdown reaching zero sets the time-out flag.
// - Time unit bit: 0 is 150 ms, 1 is 2.5 s.
// - Time-out reset pulse only with its enable set.
// - Frequency-change reset pulse only with its enable set.
// - After reset programmable mode is off.
// - Programmable mode spans 50 MHz to 248 MHz.
package fpw_pkg;

	localparam int CLK_PERIOD_NS = 4;

	// Watchdog time units in milliseconds and their cycle counts.
	localparam logic [63:0] UNIT_SHORT_MS = 64'h96;
	localparam logic [63:0] UNIT_LONG_MS = 64'h9C4;
	localparam logic [29:0] UNIT_SHORT_CYC =
		30'(UNIT_SHORT_MS * 64'hF4240 / 64'(CLK_PERIOD_NS));
	localparam logic [29:0] UNIT_LONG_CYC =
		30'(UNIT_LONG_MS * 64'hF4240 / 64'(CLK_PERIOD_NS));

	// Width of the system reset pulse.
	localparam int RST_PULSE_NS = 1000;
	localparam logic [7:0] RST_PULSE_CYC = 8'(RST_PULSE_NS / CLK_PERIOD_NS);

	// Offsets added to N and M before they reach the PLL.
	localparam logic [8:0] N_OFFSET = 9'h003;
	localparam logic [7:0] M_OFFSET = 8'h03;

	// Gear constant selectors.
	localparam logic [1:0] GEAR_G1 = 2'h0;
	localparam logic [1:0] GEAR_G2 = 2'h1;
	localparam logic [1:0] GEAR_G3 = 2'h2;
	localparam logic [1:0] GEAR_G4 = 2'h3;

	typedef struct packed {
		logic prog_enable;
		logic strap_bypass;
		logic [4:0] table_select_code;
	} fpw_freq_ctrl_t;

	typedef struct packed {
		logic watchdog_enable;
		logic watchdog_time_unit;
		logic [4:0] watchdog_timeout_value;
		logic reset_on_timeout_enable;
		logic reset_on_freq_change_enable;
		logic recovery_source_choice;
	} fpw_wd_ctrl_t;

	typedef struct packed {
		logic prog_mode;
		logic [4:0] ratio_code;
		logic [1:0] gear_sel;
		logic [8:0] pll_mult;
		logic [7:0] pll_div;
	} fpw_setting_t;

	localparam fpw_freq_ctrl_t FREQ_CTRL_RST = '0;
	localparam fpw_wd_ctrl_t WD_CTRL_RST = '0;
	localparam logic [7:0] NUM_RST = 8'h00;
	localparam logic [6:0] DEN_RST = 7'h00;

	// Gear constant that belongs to each frequency code.
	function automatic logic [1:0] gear_of(input logic [4:0] code);
		logic [1:0] g;
		g = GEAR_G3;
		unique case (code)
			5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h1C: begin
				g = GEAR_G1;
			end
			5'h01, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h1D: begin
				g = GEAR_G2;
			end
			5'h0F: begin
				g = GEAR_G4;
			end
			default: begin
				g = GEAR_G3;
			end
		endcase
		return g;
	endfunction : gear_of

	// Full setting built from a ratio code and the N/M pair.
	function automatic fpw_setting_t make_setting(input logic prog,
		input logic [4:0] code, input logic [7:0] n, input logic [6:0] m);
		fpw_setting_t s;
		s.prog_mode = prog;
		s.ratio_code = code;
		s.gear_sel = gear_of(code);
		s.pll_mult = prog ? ({1'b0, n} + N_OFFSET) : 9'h000;
		s.pll_div = prog ? ({1'b0, m} + M_OFFSET) : 8'h00;
		return s;
	endfunction : make_setting

endpackage : fpw_pkg

// file: fpw_rst_sink.sv
// System reset input model that measures every reset pulse.
module fpw_rst_sink (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Reset pulse and its measurements.
	input wire logic pulse,
	output logic [15:0] width_r,
	output logic [15:0] count_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] run_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_r <= 16'h0000;
			width_r <= 16'h0000;
			count_r <= 16'h0000;
		end else if (pulse) begin
			run_r <= run_r + 16'h0001;
		end else if (run_r != 16'h0000) begin
			width_r <= run_r;
			count_r <= count_r + 16'h0001;
			run_r <= 16'h0000;
		end
	end
endmodule : fpw_rst_sink

// file: fpw_wdog.sv
// Watchdog countdown with a selectable time unit.
module fpw_wdog #(
	parameter logic [29:0] UNIT_SHORT = fpw_pkg::UNIT_SHORT_CYC,
	parameter logic [29:0] UNIT_LONG = fpw_pkg::UNIT_LONG_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Control.
	input wire logic start,
	input wire logic stop,
	input wire logic unit_long,
	input wire logic [4:0] timeout_value,
	// Status.
	output logic expire,
	output logic running
);

	logic run_r;
	logic unit_r;
	logic [29:0] pre_r;
	logic [4:0] units_r;
	logic expire_r;
	logic [29:0] start_len;
	logic [29:0] run_len;
	logic tick;
	logic last_unit;

	assign start_len = unit_long ? UNIT_LONG : UNIT_SHORT;
	assign run_len = unit_r ? UNIT_LONG : UNIT_SHORT;
	assign tick = run_r && (pre_r == 30'h00000000);
	// A value of v runs v+1 units, so five bits span one to 32 units.
	assign last_unit = (units_r == 5'h00);
	assign expire = expire_r;
	assign running = run_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_r <= 1'b0;
			unit_r <= 1'b0;
			pre_r <= '0;
			units_r <= '0;
			expire_r <= 1'b0;
		end else begin
			expire_r <= 1'b0;
			if (stop) begin
				run_r <= 1'b0;
				pre_r <= '0;
				units_r <= '0;
			end else if (start) begin
				run_r <= 1'b1;
				unit_r <= unit_long;
				units_r <= timeout_value;
				pre_r <= start_len - 30'h00000001;
			end else if (tick) begin
				if (last_unit) begin
					run_r <= 1'b0;
					expire_r <= 1'b1;
				end else begin
					units_r <= units_r - 5'h01;
					pre_r <= run_len - 30'h00000001;
				end
			end else if (run_r) begin
				pre_r <= pre_r - 30'h00000001;
			end
		end
	end

endmodule : fpw_wdog
